// ---- verilog/emb_pkg.sv ----
// Purpose: Shared constants and types of the external memory bus lane steering block.
// Assumes: One 25 MHz system clock; the external bus advances on every second edge.
// Notes: Bank windows, width codes and transfer sizes are used by the top module and bench.
package emb_pkg;

    localparam int EMB_ADDR_W = 28;
    localparam int EMB_EXT_ADDR_W = 24;
    localparam int EMB_DATA_W = 32;
    localparam int EMB_IO_BANKS = 8;
    localparam int EMB_SD_BANKS = 2;
    localparam int EMB_BANKS = EMB_IO_BANKS + EMB_SD_BANKS;

    // Fixed bank windows loaded into the bank pointers at reset.
    localparam logic [27:0] EMB_IO_BASE0 = 28'h0000000;
    localparam logic [27:0] EMB_IO_STEP = 28'h0100000;
    localparam logic [27:0] EMB_SD0_BASE = 28'h4000000;
    localparam logic [27:0] EMB_SD1_BASE = 28'h8000000;
    localparam logic [27:0] EMB_SD_SPAN = 28'h4000000;

    // External device data widths; the boot strap uses the same codes.
    localparam logic [1:0] EMB_W8 = 2'h0;
    localparam logic [1:0] EMB_W16 = 2'h1;
    localparam logic [1:0] EMB_W32 = 2'h2;

    // Transfer sizes of an internal request.
    localparam logic [1:0] EMB_SZ_BYTE = 2'h0;
    localparam logic [1:0] EMB_SZ_HALF = 2'h1;
    localparam logic [1:0] EMB_SZ_WORD = 2'h2;

    // Cycles after reset release before the synchronised strap is captured.
    localparam logic [1:0] EMB_STRAP_SETTLE = 2'h3;

    // Pin levels while the bus is idle.
    localparam logic [7:0] EMB_IO_CS_IDLE = 8'hff;
    localparam logic [1:0] EMB_SD_CS_IDLE = 2'h3;
    localparam logic [3:0] EMB_BE_IDLE = 4'hf;

    typedef enum logic [2:0] {
        EMB_IDLE = 3'b000,
        EMB_SETUP = 3'b001,
        EMB_STROBE = 3'b010,
        EMB_RECOVER = 3'b011,
        EMB_GRANT = 3'b100
    } emb_state_t;

    typedef struct packed {
        logic [27:0] addr;
        logic write;
        logic [1:0] size;
        logic [31:0] wdata;
    } emb_req_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0] be;
    } emb_lane_t;

    function automatic logic [27:0] emb_base_default(input int idx);
        logic [27:0] base;
        base = EMB_SD1_BASE;
        if (idx < EMB_IO_BANKS) begin
            base = EMB_IO_BASE0 + EMB_IO_STEP * idx[27:0];
        end else if (idx == EMB_IO_BANKS) begin
            base = EMB_SD0_BASE;
        end
        return base;
    endfunction : emb_base_default

endpackage : emb_pkg

// ---- verilog/emb_lane.sv ----
// Purpose: External memory bus interface with bank decode and big/little endian lane steering.
// Assumes: Pins other than the clock, the reset and the internal request are asynchronous and are synchronised before use.
// Notes: Bus phases advance on the enable that also drives the clock-out pin low.

module emb_lane
    import emb_pkg::*;
#(
    parameter logic [1:0] IO_BANK_WIDTH = EMB_W32
) (
    input wire logic CLK, // System clock.
    input wire logic RST, // Asynchronous reset, active high.
    input wire emb_req_t REQ_CMD, // Internal request: address, direction, size, data.
    input wire logic REQ_VALID, // Request present.
    output logic REQ_READY, // Request taken when high with REQ_VALID, unless the synchronised master request is high in that cycle.
    output logic RSP_VALID, // One-cycle pulse, access finished.
    output logic RSP_ERR, // Address hit no bank.
    output logic [31:0] RSP_RDATA, // Read data, replicated by size.
    output logic [23:0] ADDR_OUT, // External address.
    output logic ADDR_OE, // Address pins driven.
    input wire logic [31:0] DATA_IN, // External data pins, sensed.
    output logic [31:0] DATA_OUT, // External data pins, driven value.
    output logic DATA_OE, // Data pins driven.
    input wire logic [1:0] BOOT_BANK_WIDTH_STRAP, // Bank 0 width strap.
    input wire logic ENDIAN_BIG, // High selects big-endian ordering.
    output logic READ_OUTPUT_ENABLE_N, // Output enable for I/O reads.
    output logic [7:0] IO_BANK_SELECT_N, // I/O bank chip selects.
    input wire logic SLOW_DEVICE_STALL_N, // Low stretches the I/O strobe.
    output logic BUS_CLOCK_OUT, // Clock for the memory devices.
    output logic SDRAM_CKE, // SDRAM clock enable.
    output logic [1:0] SDRAM_SELECT_N, // SDRAM chip selects.
    output logic SDRAM_ROW_STROBE_N, // SDRAM row strobe.
    output logic SDRAM_COL_STROBE_N, // SDRAM column strobe.
    output logic [3:0] LANE_WRITE_ENABLE_N, // Byte lane enables.
    output logic SHARED_WRITE_ENABLE_N, // Write enable for SDRAM and 16-bit parts.
    output logic STROBE_OE, // Strobe and select pins driven.
    input wire logic EXT_MASTER_REQUEST, // External master wants the pins.
    output logic EXT_MASTER_GRANT // Pins handed to the external master.
);

    if (IO_BANK_WIDTH > EMB_W32) begin : g_bad_width
        $error("IO_BANK_WIDTH must be 8, 16 or 32 bit");
    end

    function automatic logic [15:0] swap16(input logic [15:0] v);
        return {v[7:0], v[15:8]};
    endfunction : swap16

    function automatic logic [31:0] swap32(input logic [31:0] v);
        return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction : swap32

    // Register byte index sent on an 8-bit device for a given beat.
    function automatic logic [1:0] byte_pick(input logic [1:0] size, input logic big,
                                             input logic [1:0] beat);
        logic [1:0] k;
        k = 2'h0;
        if (size == EMB_SZ_WORD) begin
            k = big ? 2'h3 - beat : beat;
        end else if (size == EMB_SZ_HALF) begin
            k = big ? {1'b0, ~beat[0]} : {1'b0, beat[0]};
        end
        return k;
    endfunction : byte_pick

    // Pins and byte enables for one write beat.
    function automatic emb_lane_t wr_steer(input logic [1:0] width, input logic [1:0] size,
                                           input logic big, input logic [1:0] ofs,
                                           input logic [1:0] beat, input logic [31:0] d);
        emb_lane_t r;
        logic [15:0] h;
        logic [1:0] k;
        r.data = 32'h0;
        r.be = 4'h0;
        h = 16'h0;
        k = 2'h0;
        if (width == EMB_W8) begin
            k = byte_pick(size, big, beat);
            r.data = {24'h0, d[8*k +: 8]};
            r.be = 4'h1;
        end else if (width == EMB_W16) begin
            if (size == EMB_SZ_WORD) begin
                h = (big ^ beat[0]) ? d[31:16] : d[15:0];
                r.data = {16'h0, big ? swap16(h) : h};
                r.be = 4'h3;
            end else if (size == EMB_SZ_HALF) begin
                r.data = {16'h0, big ? swap16(d[15:0]) : d[15:0]};
                r.be = 4'h3;
            end else begin
                r.data = ofs[0] ? {16'h0, d[7:0], 8'h0} : {24'h0, d[7:0]};
                r.be = ofs[0] ? 4'h2 : 4'h1;
            end
        end else begin
            if (size == EMB_SZ_WORD) begin
                r.data = big ? swap32(d) : d;
                r.be = 4'hf;
            end else if (size == EMB_SZ_HALF) begin
                h = big ? swap16(d[15:0]) : d[15:0];
                r.data = ofs[1] ? {h, 16'h0} : {16'h0, h};
                r.be = ofs[1] ? 4'hc : 4'h3;
            end else begin
                r.data = {24'h0, d[7:0]} << {ofs, 3'h0};
                r.be = 4'h1 << ofs;
            end
        end
        return r;
    endfunction : wr_steer

    // Merge one read beat into the right-aligned register value.
    function automatic logic [31:0] rd_merge(input logic [1:0] width, input logic [1:0] size,
                                             input logic big, input logic [1:0] ofs,
                                             input logic [1:0] beat, input logic [31:0] p,
                                             input logic [31:0] acc);
        logic [31:0] r;
        logic [15:0] h;
        logic [1:0] k;
        r = acc;
        h = 16'h0;
        k = 2'h0;
        if (width == EMB_W8) begin
            k = byte_pick(size, big, beat);
            r[8*k +: 8] = p[7:0];
        end else if (width == EMB_W16) begin
            h = big ? swap16(p[15:0]) : p[15:0];
            if (size == EMB_SZ_WORD) begin
                if (big ^ beat[0]) begin
                    r[31:16] = h;
                end else begin
                    r[15:0] = h;
                end
            end else if (size == EMB_SZ_HALF) begin
                r = {16'h0, h};
            end else begin
                r = {24'h0, ofs[0] ? p[15:8] : p[7:0]};
            end
        end else begin
            h = ofs[1] ? p[31:16] : p[15:0];
            if (size == EMB_SZ_WORD) begin
                r = big ? swap32(p) : p;
            end else if (size == EMB_SZ_HALF) begin
                r = {16'h0, big ? swap16(h) : h};
            end else begin
                r = {24'h0, p[8*ofs +: 8]};
            end
        end
        return r;
    endfunction : rd_merge

    // Pin synchronisers: first stage feeds only the second.
    logic [1:0] stall_meta_q, mreq_meta_q, big_meta_q;
    logic stall_n_s_q, mreq_s_q, big_s_q;
    logic [1:0] strap_meta_q, strap_s_q;
    logic [31:0] din_meta_q, din_s_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            stall_meta_q <= 2'h3;
            mreq_meta_q <= 2'h0;
            big_meta_q <= 2'h0;
            stall_n_s_q <= 1'b1;
            mreq_s_q <= 1'b0;
            big_s_q <= 1'b0;
            strap_meta_q <= 2'h0;
            strap_s_q <= 2'h0;
            din_meta_q <= 32'h0;
            din_s_q <= 32'h0;
        end else begin
            stall_meta_q <= {stall_meta_q[0], SLOW_DEVICE_STALL_N};
            mreq_meta_q <= {mreq_meta_q[0], EXT_MASTER_REQUEST};
            big_meta_q <= {big_meta_q[0], ENDIAN_BIG};
            stall_n_s_q <= stall_meta_q[1];
            mreq_s_q <= mreq_meta_q[1];
            big_s_q <= big_meta_q[1];
            strap_meta_q <= BOOT_BANK_WIDTH_STRAP;
            strap_s_q <= strap_meta_q;
            din_meta_q <= DATA_IN;
            din_s_q <= din_meta_q;
        end
    end

    // Bank pointers, strap capture and divided bus clock.
    logic [27:0] base_q [EMB_BANKS];
    logic [1:0] strap_cnt_q, strap_cnt_d;
    logic [1:0] bank0_width_q, bank0_width_d;
    logic clk_out_q;
    logic tick;

    assign tick = clk_out_q;

    always_comb begin
        strap_cnt_d = strap_cnt_q;
        bank0_width_d = bank0_width_q;
        if (strap_cnt_q != EMB_STRAP_SETTLE) begin
            strap_cnt_d = strap_cnt_q + 2'h1;
            bank0_width_d = (strap_s_q > EMB_W32) ? EMB_W32 : strap_s_q;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < EMB_BANKS; i++) begin
                base_q[i] <= emb_base_default(i);
            end
            strap_cnt_q <= 2'h0;
            bank0_width_q <= EMB_W32;
            clk_out_q <= 1'b0;
        end else begin
            strap_cnt_q <= strap_cnt_d;
            bank0_width_q <= bank0_width_d;
            clk_out_q <= ~clk_out_q;
        end
    end

    // Decode of the incoming request.
    logic hit;
    logic is_sd;
    logic [3:0] bank_idx;
    logic [27:0] bank_ofs;
    logic [1:0] hit_width;

    always_comb begin
        hit = 1'b0;
        is_sd = 1'b0;
        bank_idx = 4'h0;
        bank_ofs = 28'h0;
        for (int i = 0; i < EMB_BANKS; i++) begin
            if (!hit && REQ_CMD.addr >= base_q[i] &&
                REQ_CMD.addr - base_q[i] < ((i < EMB_IO_BANKS) ? EMB_IO_STEP : EMB_SD_SPAN)) begin
                hit = 1'b1;
                is_sd = (i >= EMB_IO_BANKS);
                bank_idx = 4'(i);
                bank_ofs = REQ_CMD.addr - base_q[i];
            end
        end
        hit_width = is_sd ? EMB_W32 : ((bank_idx == 4'h0) ? bank0_width_q : IO_BANK_WIDTH);
    end

    // Access sequencer.
    emb_state_t state_q, state_d;
    emb_req_t req_q, req_d;
    logic sd_q, sd_d, big_q, big_d;
    logic [3:0] bank_q, bank_d;
    logic [1:0] width_q, width_d, beat_q, beat_d, last_q, last_d;
    logic [23:0] ea_q, ea_d;
    logic [31:0] acc_q, acc_d;
    logic ready_q, ready_d, rsp_q, rsp_d, err_q, err_d, ack_q, ack_d;
    logic hold_q, hold_d;
    logic [31:0] rdata_q, rdata_d;
    emb_lane_t lane;

    assign lane = wr_steer(width_q, req_q.size, big_q, req_q.addr[1:0], beat_q, req_q.wdata);

    always_comb begin
        state_d = state_q;
        req_d = req_q;
        sd_d = sd_q;
        big_d = big_q;
        bank_d = bank_q;
        width_d = width_q;
        beat_d = beat_q;
        last_d = last_q;
        ea_d = ea_q;
        acc_d = acc_q;
        rsp_d = 1'b0;
        hold_d = hold_q;
        err_d = err_q;
        rdata_d = rdata_q;
        ack_d = 1'b0;
        unique case (state_q)
            EMB_IDLE: begin
                if (mreq_s_q) begin
                    state_d = EMB_GRANT;
                end else if (REQ_VALID && ready_q) begin
                    req_d = REQ_CMD;
                    sd_d = is_sd;
                    bank_d = bank_idx;
                    big_d = big_s_q;
                    width_d = hit_width;
                    beat_d = 2'h0;
                    acc_d = 32'h0;
                    ea_d = 24'(bank_ofs >> hit_width);
                    last_d = 2'h0;
                    if (hit_width == EMB_W8) begin
                        last_d = (REQ_CMD.size == EMB_SZ_WORD) ? 2'h3 :
                                 (REQ_CMD.size == EMB_SZ_HALF) ? 2'h1 : 2'h0;
                    end else if (hit_width == EMB_W16 && REQ_CMD.size == EMB_SZ_WORD) begin
                        last_d = 2'h1;
                    end
                    if (hit) begin
                        state_d = EMB_SETUP;
                    end else begin
                        rsp_d = 1'b1;
                        err_d = 1'b1;
                    end
                end
            end
            EMB_SETUP: begin
                if (tick) begin
                    state_d = EMB_STROBE;
                end
            end
            EMB_STROBE: begin
                // The strobe spans at least two ticks so read data has crossed the synchroniser.
                if (tick && hold_q && (stall_n_s_q || sd_q)) begin
                    state_d = EMB_RECOVER;
                    hold_d = 1'b0;
                    acc_d = rd_merge(width_q, req_q.size, big_q, req_q.addr[1:0], beat_q,
                                     din_s_q, acc_q);
                end else if (tick) begin
                    hold_d = 1'b1;
                end
            end
            EMB_RECOVER: begin
                if (tick) begin
                    if (beat_q != last_q) begin
                        beat_d = beat_q + 2'h1;
                        ea_d = ea_q + 24'h1;
                        state_d = EMB_SETUP;
                    end else begin
                        state_d = EMB_IDLE;
                        rsp_d = 1'b1;
                        err_d = 1'b0;
                        unique case (req_q.size)
                            EMB_SZ_BYTE: rdata_d = {4{acc_q[7:0]}};
                            EMB_SZ_HALF: rdata_d = {2{acc_q[15:0]}};
                            default: rdata_d = acc_q;
                        endcase
                    end
                end
            end
            EMB_GRANT: begin
                ack_d = mreq_s_q;
                if (!mreq_s_q) begin
                    state_d = EMB_IDLE;
                end
            end
            default: state_d = EMB_IDLE;
        endcase
        ready_d = (state_d == EMB_IDLE) && !mreq_s_q && (strap_cnt_q == EMB_STRAP_SETTLE) &&
                  !(state_q == EMB_IDLE && REQ_VALID && ready_q);
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_q <= EMB_IDLE;
            req_q <= '0;
            sd_q <= 1'b0;
            big_q <= 1'b0;
            bank_q <= 4'h0;
            width_q <= EMB_W32;
            beat_q <= 2'h0;
            last_q <= 2'h0;
            ea_q <= 24'h0;
            acc_q <= 32'h0;
            ready_q <= 1'b0;
            rsp_q <= 1'b0;
            hold_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h0;
            ack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            sd_q <= sd_d;
            big_q <= big_d;
            bank_q <= bank_d;
            width_q <= width_d;
            beat_q <= beat_d;
            last_q <= last_d;
            ea_q <= ea_d;
            acc_q <= acc_d;
            ready_q <= ready_d;
            rsp_q <= rsp_d;
            hold_q <= hold_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    // Pin drivers, registered from the current access.
    logic active, strobe, rd_io;
    logic [23:0] addr_pin_d, addr_pin_q;
    logic [31:0] dout_d, dout_q;
    logic doe_d, doe_q, oe_n_d, oe_n_q, ras_d, ras_q, cas_d, cas_q, we_d, we_q;
    logic [7:0] io_cs_d, io_cs_q;
    logic [1:0] sd_cs_d, sd_cs_q;
    logic [3:0] be_d, be_q;
    logic cke_q, pins_oe_q;

    always_comb begin
        active = (state_q == EMB_SETUP) || (state_q == EMB_STROBE);
        strobe = (state_q == EMB_STROBE);
        rd_io = strobe && !sd_q && !req_q.write;
        addr_pin_d = ea_q;
        dout_d = lane.data;
        doe_d = active && req_q.write;
        oe_n_d = !rd_io;
        io_cs_d = EMB_IO_CS_IDLE;
        sd_cs_d = EMB_SD_CS_IDLE;
        if (active && !sd_q) begin
            io_cs_d[bank_q[2:0]] = 1'b0;
        end
        if (active && sd_q) begin
            sd_cs_d[bank_q[0]] = 1'b0;
        end
        ras_d = !(sd_q && state_q == EMB_SETUP);
        cas_d = !(sd_q && strobe);
        we_d = !(strobe && req_q.write && (sd_q || width_q == EMB_W16));
        be_d = (strobe && req_q.write) ? ~lane.be : EMB_BE_IDLE;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            addr_pin_q <= 24'h0;
            dout_q <= 32'h0;
            doe_q <= 1'b0;
            oe_n_q <= 1'b1;
            io_cs_q <= EMB_IO_CS_IDLE;
            sd_cs_q <= EMB_SD_CS_IDLE;
            ras_q <= 1'b1;
            cas_q <= 1'b1;
            we_q <= 1'b1;
            be_q <= EMB_BE_IDLE;
            cke_q <= 1'b0;
            pins_oe_q <= 1'b1;
        end else begin
            cke_q <= 1'b1;
            pins_oe_q <= !ack_d;
            addr_pin_q <= addr_pin_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
            oe_n_q <= oe_n_d;
            io_cs_q <= io_cs_d;
            sd_cs_q <= sd_cs_d;
            ras_q <= ras_d;
            cas_q <= cas_d;
            we_q <= we_d;
            be_q <= be_d;
        end
    end

    // While granted the enables fall and the pins float.
    assign ADDR_OE = pins_oe_q;
    assign STROBE_OE = pins_oe_q;
    assign DATA_OE = doe_q;
    assign EXT_MASTER_GRANT = ack_q;
    assign SDRAM_CKE = cke_q;
    assign REQ_READY = ready_q;
    assign RSP_VALID = rsp_q;
    assign RSP_ERR = err_q;
    assign RSP_RDATA = rdata_q;
    assign ADDR_OUT = addr_pin_q;
    assign DATA_OUT = dout_q;
    assign READ_OUTPUT_ENABLE_N = oe_n_q;
    assign IO_BANK_SELECT_N = io_cs_q;
    assign BUS_CLOCK_OUT = clk_out_q;
    assign SDRAM_SELECT_N = sd_cs_q;
    assign SDRAM_ROW_STROBE_N = ras_q;
    assign SDRAM_COL_STROBE_N = cas_q;
    assign LANE_WRITE_ENABLE_N = be_q;
    assign SHARED_WRITE_ENABLE_N = we_q;

endmodule : emb_lane

// ---- verification/emb_lane_monitor.sv ----
// Purpose: Pin protocol checks for the external bus block.
// Assumes: Sees only the top module pins.
// Notes: Every check pauses while reset is high.
module emb_lane_monitor (
    input wire logic CLK, // Clock.
    input wire logic RST, // Reset.
    input wire logic [7:0] IO_BANK_SELECT_N, // Pin.
    input wire logic READ_OUTPUT_ENABLE_N, // Pin.
    input wire logic DATA_OE, // Pin.
    input wire logic [3:0] LANE_WRITE_ENABLE_N, // Pin.
    input wire logic SHARED_WRITE_ENABLE_N, // Pin.
    input wire logic [1:0] SDRAM_SELECT_N, // Pin.
    input wire logic SDRAM_ROW_STROBE_N, // Pin.
    input wire logic SDRAM_COL_STROBE_N, // Pin.
    input wire logic SDRAM_CKE, // Pin.
    input wire logic BUS_CLOCK_OUT, // Pin.
    input wire logic SLOW_DEVICE_STALL_N, // Pin.
    input wire logic EXT_MASTER_REQUEST, // Pin.
    input wire logic EXT_MASTER_GRANT, // Pin.
    input wire logic ADDR_OE, // Pin.
    input wire logic STROBE_OE // Pin.
);
    default clocking dc @(posedge CLK); endclocking
    default disable iff (RST);
    sequence stall_held; !SLOW_DEVICE_STALL_N [*3]; endsequence
    sequence req_gone; !EXT_MASTER_REQUEST [*3]; endsequence
    read_enable_a: assert property (
        !READ_OUTPUT_ENABLE_N |-> !DATA_OE && IO_BANK_SELECT_N != 8'hff) else $error("oe");
    lane_valid_a: assert property (
        LANE_WRITE_ENABLE_N != 4'hf |-> DATA_OE && READ_OUTPUT_ENABLE_N) else $error("be");
    shared_we_a: assert property (
        !SHARED_WRITE_ENABLE_N |-> DATA_OE && LANE_WRITE_ENABLE_N != 4'hf) else $error("we");
    sdram_strobe_a: assert property (
        !SDRAM_ROW_STROBE_N || !SDRAM_COL_STROBE_N |-> $onehot(~SDRAM_SELECT_N) && SDRAM_CKE)
        else $error("sdram");
    clock_out_a: assert property (
        !$past(RST) |-> BUS_CLOCK_OUT != $past(BUS_CLOCK_OUT)) else $error("clock out");
    grant_release_a: assert property (
        EXT_MASTER_GRANT |-> !ADDR_OE && !STROBE_OE) else $error("release");
    grant_drop_a: assert property (
        req_gone ##0 EXT_MASTER_GRANT |-> ##[0:3] !EXT_MASTER_GRANT) else $error("grant");
    stall_hold_a: assert property (
        stall_held ##0 !READ_OUTPUT_ENABLE_N |=> !READ_OUTPUT_ENABLE_N) else $error("stall");
endmodule : emb_lane_monitor
bind emb_lane emb_lane_monitor u_emb_lane_monitor (.*);

// ---- verification/emb_ext_mem.sv ----
// Purpose: Behavioural memory and I/O device on the external pins.
// Assumes: Sixteen words decoded from the low address bits, shared by all banks.
// Notes: Released data pins show the inverse of the last value.
module emb_ext_mem (
    input wire logic CLK, // Clock.
    input wire logic STALL_MODE, // Slow device.
    input wire logic [23:0] ADDR_OUT, // Address.
    input wire logic [31:0] DATA_OUT, // Driven data.
    input wire logic DATA_OE, // Data driven.
    input wire logic READ_OUTPUT_ENABLE_N, // Read enable.
    input wire logic [7:0] IO_BANK_SELECT_N, // Selects.
    input wire logic [1:0] SDRAM_SELECT_N, // Selects.
    input wire logic SDRAM_COL_STROBE_N, // Strobe.
    input wire logic SHARED_WRITE_ENABLE_N, // Write enable.
    input wire logic [3:0] LANE_WRITE_ENABLE_N, // Lanes.
    output logic [31:0] DATA_IN, // Sensed data.
    output logic SLOW_DEVICE_STALL_N // Wait line.
);
    logic [31:0] mem [16] = '{default: 32'h0};
    logic [31:0] held_q = 32'h0;
    logic [33:0] last_q = 34'h0;
    logic [3:0] cnt_q = 4'h0;
    logic io;
    assign io = IO_BANK_SELECT_N != 8'hff;
    assign DATA_IN = DATA_OE ? DATA_OUT : (!READ_OUTPUT_ENABLE_N || (!SDRAM_COL_STROBE_N &&
        SHARED_WRITE_ENABLE_N && SDRAM_SELECT_N != 2'h3)) ? mem[ADDR_OUT[3:0]] : ~held_q;
    // A slow device holds the wait line low from before the select until six select cycles.
    assign SLOW_DEVICE_STALL_N = !(STALL_MODE && cnt_q < 4'h6);
    always @(posedge CLK) begin
        held_q <= DATA_IN;
        cnt_q <= io ? cnt_q + {3'h0, cnt_q < 4'h6} : 4'h0;
        if (io || SDRAM_SELECT_N != 2'h3) last_q <= {SDRAM_SELECT_N, IO_BANK_SELECT_N, ADDR_OUT};
        for (int i = 0; i < 4; i++) begin
            if (!LANE_WRITE_ENABLE_N[i]) mem[ADDR_OUT[3:0]][8*i+:8] <= DATA_OUT[8*i+:8];
        end
    end
endmodule : emb_ext_mem

// ---- verification/emb_lane_tb.sv ----
// Purpose: Self-checking bench of the external bus block with a device model.
// Assumes: Bank 0 is 32 bits wide until the strap changes for the last part.
// Notes: Random accesses come from a fixed xorshift seed.
module emb_lane_tb
    import emb_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, ENDIAN_BIG = 1'b1, STALL_MODE = 1'b0;
    logic EXT_MASTER_REQUEST = 1'b0, REQ_READY, RSP_VALID, RSP_ERR, ADDR_OE, DATA_OE, STROBE_OE;
    logic READ_OUTPUT_ENABLE_N, SLOW_DEVICE_STALL_N, BUS_CLOCK_OUT, SDRAM_CKE, EXT_MASTER_GRANT;
    logic SDRAM_ROW_STROBE_N, SDRAM_COL_STROBE_N, SHARED_WRITE_ENABLE_N;
    logic [1:0] BOOT_BANK_WIDTH_STRAP = EMB_W32, SDRAM_SELECT_N;
    logic [3:0] LANE_WRITE_ENABLE_N;
    logic [7:0] IO_BANK_SELECT_N;
    logic [23:0] ADDR_OUT;
    logic [31:0] DATA_IN, DATA_OUT, RSP_RDATA, seed = 32'h0000e4bd;
    logic [31:0] ref_m [16] = '{default: 32'h0};
    emb_req_t REQ_CMD = '0;
    int errors = 0, checked = 0;
    always #20 CLK = ~CLK;
    emb_lane u_emb_lane (.*);
    emb_ext_mem u_emb_ext_mem (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // Pin image of a register value, or register image of pin lanes, for one transfer.
    function automatic logic [31:0] img(input logic [31:0] v, input logic [1:0] sz, o,
            input logic big);
        logic [31:0] x;
        x = sz == EMB_SZ_BYTE ? {4{v[8*o+:8]}} : sz == EMB_SZ_HALF ? {2{v[16*o[1]+:16]}} : v;
        if (!big || sz == EMB_SZ_BYTE) return x;
        if (sz == EMB_SZ_HALF) return {x[23:16], x[31:24], x[7:0], x[15:8]};
        return {x[7:0], x[15:8], x[23:16], x[31:24]};
    endfunction : img
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wrap_up();
        if (errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic acc(input emb_req_t c);
        int n;
        n = 0;
        do @(posedge CLK); while (REQ_READY !== 1'b1 && n++ < 500);
        REQ_CMD <= c;
        REQ_VALID <= 1'b1;
        do @(posedge CLK); while (REQ_READY !== 1'b1 && n++ < 500);
        REQ_VALID <= 1'b0;
        do @(posedge CLK); while (RSP_VALID !== 1'b1 && n++ < 500);
        if (RSP_VALID !== 1'b1) begin
            errors++;
            wrap_up();
        end
    endtask : acc
    initial begin
        logic [31:0] r, d, x;
        logic [27:0] a;
        logic [3:0] m, w;
        logic [1:0] sz, o;
        int k;
        repeat (16) @(posedge CLK);
        RST <= 1'b0;
        for (int i = 0; i < 300; i++) begin
            r = rnd();
            d = rnd();
            k = r[3:0] % 10;
            w = r[11:8];
            sz = r[5:4] % 3;
            o = sz == EMB_SZ_WORD ? 2'h0 : {r[7], r[6] & (sz == EMB_SZ_BYTE)};
            a = (k < 8 ? EMB_IO_STEP * k : k == 8 ? EMB_SD0_BASE : EMB_SD1_BASE) + {w, o};
            m = sz == EMB_SZ_WORD ? 4'hf : sz == EMB_SZ_HALF ? 4'h3 << o : 4'h1 << o;
            ENDIAN_BIG <= r[12];
            STALL_MODE <= r[13];
            repeat (3) @(posedge CLK);
            x = img(d, sz, 2'h0, r[12]);
            for (int j = 0; j < 4; j++) if (r[14] && m[j]) ref_m[w][8*j+:8] = x[8*j+:8];
            acc('{a, r[14], sz, d});
            if (r[14]) cmp(u_emb_ext_mem.mem[w], ref_m[w]);
            else cmp(RSP_RDATA, img(ref_m[w], sz, o, r[12]));
            cmp(u_emb_ext_mem.last_q, {k == 8 ? 2'h2 : k == 9 ? 2'h1 : 2'h3,
                k < 8 ? ~(8'h1 << k) : 8'hff, 20'h0, w});
        end
        acc('{28'h2000000, 1'b0, EMB_SZ_WORD, 32'h0});
        cmp(RSP_ERR, 1'b1);
        EXT_MASTER_REQUEST <= 1'b1;
        for (int n = 0; n < 20 && EXT_MASTER_GRANT !== 1'b1; n++) @(posedge CLK);
        cmp({EXT_MASTER_GRANT, ADDR_OE, STROBE_OE}, 3'h4);
        EXT_MASTER_REQUEST <= 1'b0;
        for (int n = 0; n < 20 && EXT_MASTER_GRANT !== 1'b0; n++) @(posedge CLK);
        cmp(EXT_MASTER_GRANT, 1'b0);
        RST <= 1'b1;
        BOOT_BANK_WIDTH_STRAP <= EMB_W16;
        ENDIAN_BIG <= 1'b1;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        acc('{28'h0, 1'b1, EMB_SZ_WORD, 32'h11223344});
        cmp({u_emb_ext_mem.mem[1][15:0], u_emb_ext_mem.mem[0][15:0]}, 32'h44332211);
        acc('{28'h1, 1'b1, EMB_SZ_BYTE, 32'h55667788});
        cmp(u_emb_ext_mem.mem[0][15:0], 16'h8811);
        wrap_up();
    end
endmodule : emb_lane_tb
